/* inc/adp_map.svh */
`ifndef ADP_MAP_SVH
`define ADP_MAP_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define ADP_IDX_HAP_DDR 16'hFFB1
`define ADP_IDX_HAP_DR 16'hFFB3
`define ADP_IDX_DBP_DDR 16'hFFB4
`define ADP_IDX_DBP_DR 16'hFFB6
`define ADP_IDX_CTRL 16'hFFC0

// ----------------------------------------
// Reset values and fixed patterns
// ----------------------------------------
`define ADP_RST_PORT 8'h00
`define ADP_ALL_ONES 8'hFF
`define ADP_RST_SRE 1'b0

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ADP_CTRL_SRE_BIT 0
`define ADP_CTRL_MODE_LSB 1

// ----------------------------------------
// Mode strap codes
// ----------------------------------------
`define ADP_STRAP_M1 2'h1
`define ADP_STRAP_M2 2'h2

`endif

/* inc/adp_pkg.sv */
`default_nettype none

package adp_pkg;
	// Operating mode caught from the strap
	typedef enum logic [1:0] {
		ADP_MODE_1,
		ADP_MODE_2,
		ADP_MODE_3
	} adp_mode_t;

	// Register selected by the pending data phase
	typedef enum logic [2:0] {
		ADP_SEL_NONE,
		ADP_SEL_HAP_DDR,
		ADP_SEL_HAP_DR,
		ADP_SEL_DBP_DDR,
		ADP_SEL_DBP_DR,
		ADP_SEL_CTRL
	} adp_sel_t;
endpackage : adp_pkg

`default_nettype wire

/* src/adp_gpio_bits.sv */
`default_nettype none

// Per-bit read path and pull-up control of one general-purpose port
module adp_gpio_bits #(
	parameter int W = 8
) (
	input wire logic [W-1:0] ddr,
	input wire logic [W-1:0] dr,
	input wire logic [W-1:0] pin_in,
	input wire logic pu_allow,
	output logic [W-1:0] rd_val,
	output logic [W-1:0] pu_en
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (W < 1 || W > 32) begin : g_bad_w
		$error("adp_gpio_bits: W must be 1 to 32");
	end

	// Outputs read the latch, inputs read the live pin
	assign rd_val = (ddr & dr) | (~ddr & pin_in); // see [R6]

	// Pull-up only on an input whose data bit is one
	assign pu_en = ~ddr & dr & {W{pu_allow}}; // see [R7]
endmodule : adp_gpio_bits

`default_nettype wire

/* src/adp_ports.sv */
// The AHB-Lite slave port was decided locally.
`include "adp_map.svh"
`default_nettype none

// What this block does
// [R1] Mode 1: address high byte always out on address port, pull-ups off.
// [R2] Mode 1: address port direction ignores writes, holds all ones.
// [R3] Mode 2: per pin, direction 0 is input, 1 is address output.
// [R4] General use: direction bit 1 makes output, 0 input; direction write-only.
// [R5] Reading either direction register returns all ones.
// [R6] Data read gives latch for outputs, live pin for inputs.
// [R7] Modes 2, 3: address port pull-up on input pin with data one.
// [R8] Reset clears address port registers; mode 1 then sets direction all ones.
// [R9] Hardware standby floats address port pins, pull-ups off.
// [R10] Software standby keeps registers; address pins low, general outputs hold.
// [R11] Modes 1, 2: data port is external data bus, registers ignored.
// [R12] Mode 3: data port general I/O, or shared RAM bus when enabled.
// [R13] Data port pull-ups only mode 3 without shared RAM; slave keeps data zero.
// [R14] Reset or hardware standby clears data port registers and shared RAM enable.
// [R15] Software standby keeps data port state; floats in modes 1, 2 and slave.
// [R16] Address pin n carries address bit 8 plus n.
// [R17] External data bus is driven only in device write cycles.
module adp_ports
	import adp_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] mode_strap,
	input wire logic hw_stby,
	input wire logic sw_stby,
	input wire logic [PORT_W-1:0] addr_hi,
	input wire logic ext_wr,
	input wire logic [PORT_W-1:0] ext_wdata,
	input wire logic shram_drive,
	input wire logic [PORT_W-1:0] shram_rdata,
	input wire logic [PORT_W-1:0] hap_in,
	output logic [PORT_W-1:0] hap_out,
	output logic [PORT_W-1:0] hap_oe,
	output logic [PORT_W-1:0] hap_pu,
	input wire logic [PORT_W-1:0] dbp_in,
	output logic [PORT_W-1:0] dbp_out,
	output logic [PORT_W-1:0] dbp_oe,
	output logic [PORT_W-1:0] dbp_pu
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (PORT_W != 8) begin : g_bad_w
		$error("adp_ports: ports are eight bits wide");
	end

	localparam logic [PORT_W-1:0] ONES = `ADP_ALL_ONES;
	localparam logic [PORT_W-1:0] ZERO = `ADP_RST_PORT;

	adp_mode_t mode_ff;
	adp_sel_t sel_ff;
	adp_sel_t nxt_sel;
	logic wr_ph_ff;
	logic rd_ph_ff;
	logic [PORT_W-1:0] hap_ddr_ff;
	logic [PORT_W-1:0] hap_dr_ff;
	logic [PORT_W-1:0] dbp_ddr_ff;
	logic [PORT_W-1:0] dbp_dr_ff;
	logic sre_ff;
	logic [PORT_W-1:0] hap_rd;
	logic [PORT_W-1:0] hap_gp_pu;
	logic [PORT_W-1:0] dbp_rd;
	logic [PORT_W-1:0] dbp_gp_pu;
	logic [15:0] a_idx;
	logic a_ok;
	logic a_take;
	logic [PORT_W-1:0] wbyte;

	// ----------------------------------------
	// Mode strap
	// ----------------------------------------

	// Strap is caught while reset is held
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			if (mode_strap == `ADP_STRAP_M1)
				mode_ff <= ADP_MODE_1;
			else if (mode_strap == `ADP_STRAP_M2)
				mode_ff <= ADP_MODE_2;
			else
				mode_ff <= ADP_MODE_3;
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address decode on word index
	assign a_idx = haddr[17:2];
	assign a_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
	assign a_take = hsel && htrans[1] && hready;
	assign wbyte = hwdata[PORT_W-1:0];

	always_comb begin
		nxt_sel = ADP_SEL_NONE;
		if (a_ok) begin
			unique case (a_idx)
				`ADP_IDX_HAP_DDR: nxt_sel = ADP_SEL_HAP_DDR;
				`ADP_IDX_HAP_DR: nxt_sel = ADP_SEL_HAP_DR;
				`ADP_IDX_DBP_DDR: nxt_sel = ADP_SEL_DBP_DDR;
				`ADP_IDX_DBP_DR: nxt_sel = ADP_SEL_DBP_DR;
				`ADP_IDX_CTRL: nxt_sel = ADP_SEL_CTRL;
				default: nxt_sel = ADP_SEL_NONE;
			endcase
		end
	end

	// Address phase captured for the data phase
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_ff <= ADP_SEL_NONE;
			wr_ph_ff <= 1'b0;
			rd_ph_ff <= 1'b0;
		end else if (hready) begin
			sel_ff <= a_take ? nxt_sel : ADP_SEL_NONE;
			wr_ph_ff <= a_take && hwrite;
			rd_ph_ff <= a_take && !hwrite;
		end
	end

	// Read mux; unmapped reads zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_ph_ff) begin
			unique case (sel_ff)
				ADP_SEL_HAP_DDR: hrdata[PORT_W-1:0] = ONES; // see [R5] [R4]
				ADP_SEL_DBP_DDR: hrdata[PORT_W-1:0] = ONES; // see [R5]
				ADP_SEL_HAP_DR: hrdata[PORT_W-1:0] = hap_rd; // see [R6]
				ADP_SEL_DBP_DR: hrdata[PORT_W-1:0] = dbp_rd; // see [R6]
				ADP_SEL_CTRL: begin
					hrdata[`ADP_CTRL_SRE_BIT] = sre_ff;
					hrdata[`ADP_CTRL_MODE_LSB +: 2] = mode_ff;
				end
				ADP_SEL_NONE: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Address port registers
	// ----------------------------------------

	// Direction: mode 1 forces all ones after reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			hap_ddr_ff <= ZERO; // see [R8]
		else if (mode_ff == ADP_MODE_1)
			hap_ddr_ff <= ONES; // see [R2] [R8]
		else if (wr_ph_ff && sel_ff == ADP_SEL_HAP_DDR)
			hap_ddr_ff <= wbyte; // see [R4]
	end

	// Data latch
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			hap_dr_ff <= ZERO; // see [R8]
		else if (wr_ph_ff && sel_ff == ADP_SEL_HAP_DR)
			hap_dr_ff <= wbyte;
	end

	// ----------------------------------------
	// Data port registers
	// ----------------------------------------

	// Hardware standby clears these as reset does
	always_ff @(posedge clk_sys) begin
		if (sys_rst || hw_stby)
			dbp_ddr_ff <= ZERO; // see [R14]
		else if (wr_ph_ff && sel_ff == ADP_SEL_DBP_DDR)
			dbp_ddr_ff <= wbyte;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || hw_stby)
			dbp_dr_ff <= ZERO; // see [R14]
		else if (wr_ph_ff && sel_ff == ADP_SEL_DBP_DR)
			dbp_dr_ff <= wbyte;
	end

	// Shared RAM enable
	always_ff @(posedge clk_sys) begin
		if (sys_rst || hw_stby)
			sre_ff <= `ADP_RST_SRE; // see [R14]
		else if (wr_ph_ff && sel_ff == ADP_SEL_CTRL)
			sre_ff <= hwdata[`ADP_CTRL_SRE_BIT];
	end

	// ----------------------------------------
	// Per-bit read and pull-up paths
	// ----------------------------------------
	adp_gpio_bits #(
		.W(PORT_W)
	) u_hap_bits (
		.ddr(hap_ddr_ff),
		.dr(hap_dr_ff),
		.pin_in(hap_in),
		.pu_allow(mode_ff != ADP_MODE_1), // see [R7]
		.rd_val(hap_rd),
		.pu_en(hap_gp_pu)
	);

	adp_gpio_bits #(
		.W(PORT_W)
	) u_dbp_bits (
		.ddr(dbp_ddr_ff),
		.dr(dbp_dr_ff),
		.pin_in(dbp_in),
		.pu_allow(mode_ff == ADP_MODE_3 && !sre_ff), // see [R13]
		.rd_val(dbp_rd),
		.pu_en(dbp_gp_pu)
	);

	// ----------------------------------------
	// Address port pins
	// ----------------------------------------

	// Hardware standby floats; software standby drives address low
	always_comb begin
		hap_out = hap_dr_ff;
		hap_oe = ZERO;
		hap_pu = ZERO;
		if (!hw_stby && !sys_rst) begin // see [R9] [R8]
			unique case (mode_ff)
				ADP_MODE_1: begin
					hap_oe = ONES; // see [R1]
					hap_out = sw_stby ? ZERO : addr_hi; // see [R10] [R16]
				end
				ADP_MODE_2: begin
					hap_oe = hap_ddr_ff; // see [R3]
					hap_out = sw_stby ? ZERO : addr_hi; // see [R10] [R16]
					hap_pu = hap_gp_pu; // see [R7]
				end
				ADP_MODE_3: begin
					hap_oe = hap_ddr_ff; // see [R4] [R10]
					hap_out = hap_dr_ff;
					hap_pu = hap_gp_pu; // see [R7]
				end
				default: hap_oe = ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// Data port pins
	// ----------------------------------------

	// Bus, shared RAM bus or general I/O by mode
	always_comb begin
		dbp_out = dbp_dr_ff;
		dbp_oe = ZERO;
		dbp_pu = ZERO;
		if (!hw_stby && !sys_rst) begin // see [R14]
			unique case (mode_ff)
				ADP_MODE_1, ADP_MODE_2: begin
					dbp_out = ext_wdata; // see [R11]
					dbp_oe = sw_stby ? ZERO : {PORT_W{ext_wr}}; // see [R17] [R15]
				end
				ADP_MODE_3: begin
					if (sre_ff) begin
						dbp_out = shram_rdata; // see [R12]
						dbp_oe = sw_stby ? ZERO : {PORT_W{shram_drive}}; // see [R15]
					end else begin
						dbp_oe = dbp_ddr_ff; // see [R12] [R15]
						dbp_pu = dbp_gp_pu; // see [R13]
					end
				end
				default: dbp_oe = ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	chk_m1_addr_out: assert property ( // see [R1] [R16]
		(mode_ff == ADP_MODE_1 && !hw_stby && !sw_stby)
		|-> (hap_oe == ONES && hap_out == addr_hi && hap_pu == ZERO))
		else $error("mode 1 address byte not driven");

	chk_m1_ddr_ones: assert property ( // see [R2]
		(mode_ff == ADP_MODE_1) |=> (hap_ddr_ff == ONES) [*2])
		else $error("mode 1 direction not all ones");

	chk_m2_pin_split: assert property ( // see [R3]
		(mode_ff == ADP_MODE_2 && !hw_stby && !sw_stby)
		|-> (hap_oe == hap_ddr_ff && ((hap_out ^ addr_hi) & hap_ddr_ff) == ZERO))
		else $error("mode 2 pin split wrong");

	chk_ddr_write_takes: assert property ( // see [R4]
		(wr_ph_ff && sel_ff == ADP_SEL_DBP_DDR && !hw_stby)
		|=> (dbp_ddr_ff == $past(wbyte)))
		else $error("direction write lost");

	chk_ddr_read_ones: assert property ( // see [R5]
		(rd_ph_ff && (sel_ff == ADP_SEL_HAP_DDR || sel_ff == ADP_SEL_DBP_DDR))
		|-> (hrdata == 32'h0000_00FF))
		else $error("direction read not all ones");

	chk_dr_read_mux: assert property ( // see [R6]
		(rd_ph_ff && sel_ff == ADP_SEL_HAP_DR)
		|-> (hrdata[7:0] == ((hap_dr_ff & hap_ddr_ff) | (hap_in & ~hap_ddr_ff))))
		else $error("data read mux wrong");

	chk_dbp_read_mux: assert property ( // see [R6]
		(rd_ph_ff && sel_ff == ADP_SEL_DBP_DR)
		|-> (hrdata[7:0] == ((dbp_dr_ff & dbp_ddr_ff) | (dbp_in & ~dbp_ddr_ff))))
		else $error("data port read mux wrong");

	chk_hap_pullup: assert property ( // see [R7]
		(mode_ff == ADP_MODE_3 && !hw_stby)
		|-> (hap_pu == (~hap_ddr_ff & hap_dr_ff)))
		else $error("address port pull-up wrong");

	chk_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0) // see [R8] [R14]
		sys_rst |=> (hap_dr_ff == ZERO && dbp_ddr_ff == ZERO && !sre_ff))
		else $error("reset did not clear");

	chk_hw_stby_float: assert property ( // see [R9]
		hw_stby |-> (hap_oe == ZERO && hap_pu == ZERO && dbp_oe == ZERO))
		else $error("hardware standby not floating");

	chk_swsb_addr_low: assert property ( // see [R10]
		(sw_stby && !hw_stby && mode_ff != ADP_MODE_3)
		|-> ((hap_out & hap_oe) == ZERO))
		else $error("standby address pins not low");

	chk_ext_bus: assert property ( // see [R11] [R17]
		(mode_ff != ADP_MODE_3 && !hw_stby && !sw_stby)
		|-> (dbp_oe == {PORT_W{ext_wr}} && dbp_pu == ZERO))
		else $error("external data bus drive wrong");

	chk_dbp_pullup: assert property ( // see [R13]
		(mode_ff != ADP_MODE_3 || sre_ff) |-> (dbp_pu == ZERO))
		else $error("data port pull-up outside general use");

	chk_swsb_float: assert property ( // see [R15]
		(sw_stby && (mode_ff != ADP_MODE_3 || sre_ff)) |-> (dbp_oe == ZERO))
		else $error("data port not floating in standby");

	chk_hwsb_clear: assert property ( // see [R14]
		hw_stby |=> (dbp_dr_ff == ZERO && dbp_ddr_ff == ZERO && !sre_ff))
		else $error("hardware standby did not clear");

	chk_slave_bus: assert property ( // see [R12]
		(mode_ff == ADP_MODE_3 && sre_ff && !hw_stby && !sw_stby)
		|-> (dbp_oe == {PORT_W{shram_drive}} && dbp_out == shram_rdata))
		else $error("shared RAM bus wrong");
endmodule : adp_ports

`default_nettype wire

/* tb/adp_pin_model.sv */
`default_nettype none

// ----------------------------------------
// Far-side pin model
// ----------------------------------------
module adp_pin_model (
	input wire logic clk_sys,
	input wire logic [7:0] oe,
	input wire logic [7:0] dout,
	input wire logic [7:0] pu,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] lvl
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] flt_ff = 8'h55;
	// Free lines with no pull-up wander every cycle
	always_ff @(posedge clk_sys) begin
		flt_ff <= ~flt_ff;
	end
	// Device drive wins; the far side only drives pins the device leaves free
	always_comb begin
		lvl = (oe & dout) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | flt_ff));
	end
endmodule : adp_pin_model

`default_nettype wire

/* tb/test_address_data_io_ports.sv */
`include "adp_map.svh"
`default_nettype none

// ----------------------------------------
// Bench top
// ----------------------------------------
module test_address_data_io_ports;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] mode_strap = 2'h3;
	logic hw_stby = 1'b0;
	logic sw_stby = 1'b0;
	logic ext_wr = 1'b0;
	logic shram_drive = 1'b0;
	logic [7:0] addr_hi = 8'h00;
	logic [7:0] ext_wdata = 8'h00;
	logic [7:0] shram_rdata = 8'h00;
	logic [7:0] x_en = 8'hFF;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [7:0] hap_in, hap_out, hap_oe, hap_pu, dbp_in, dbp_out, dbp_oe, dbp_pu;
	int num_errors = 0;
	int checks = 0;
	localparam logic [31:0] A_HDIR = 32'(`ADP_IDX_HAP_DDR) * 4;
	localparam logic [31:0] A_HDR = 32'(`ADP_IDX_HAP_DR) * 4;
	localparam logic [31:0] A_DDIR = 32'(`ADP_IDX_DBP_DDR) * 4;
	localparam logic [31:0] A_DDR = 32'(`ADP_IDX_DBP_DR) * 4;
	localparam logic [31:0] A_CTRL = 32'(`ADP_IDX_CTRL) * 4;
	localparam logic [31:0] A_BAD = 32'h0000_0100;

	adp_ports DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode_strap(mode_strap),
		.hw_stby(hw_stby), .sw_stby(sw_stby), .addr_hi(addr_hi), .ext_wr(ext_wr),
		.ext_wdata(ext_wdata), .shram_drive(shram_drive), .shram_rdata(shram_rdata),
		.hap_in(hap_in), .hap_out(hap_out), .hap_oe(hap_oe), .hap_pu(hap_pu),
		.dbp_in(dbp_in), .dbp_out(dbp_out), .dbp_oe(dbp_oe), .dbp_pu(dbp_pu));
	adp_pin_model hap_far (.clk_sys(clk_sys), .oe(hap_oe), .dout(hap_out), .pu(hap_pu),
		.ext_en(x_en), .ext_val(8'h3C), .lvl(hap_in));
	adp_pin_model dbp_far (.clk_sys(clk_sys), .oe(dbp_oe), .dout(dbp_out), .pu(dbp_pu),
		.ext_en(x_en), .ext_val(8'h3A), .lvl(dbp_in));

	// 100 MHz clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic finish_test;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: pins got %h exp %h", $time, g, e);
		end
	endtask : chk8

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: read got %h exp %h", $time, g, e);
		end
	endtask : chk32

	// Bounded wait for ready at a rising edge
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			$display("Error %0t: bus hang", $time);
			finish_test();
		end
	endtask : wait_rdy

	// One single word transfer: address phase, then data phase
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		ahb(1'b1, a, {24'h00_0000, d}, q);
	endtask : wr

	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0000_0000, q);
		chk32(q, e);
		chk8({7'h00, hresp}, 8'h00);
	endtask : rc

	// Standby inputs change at a rising edge; pins are looked at on the falling one
	task automatic go(input logic hw, input logic sw);
		@(posedge clk_sys);
		hw_stby <= hw;
		sw_stby <= sw;
		@(negedge clk_sys);
	endtask : go

	task automatic do_reset(input logic [1:0] s);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		mode_strap <= s;
		repeat (9) @(posedge clk_sys);
		@(negedge clk_sys);
		chk8(hap_oe, 8'h00);
		chk8(hap_pu, 8'h00);
		chk8(dbp_oe, 8'h00);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
	endtask : do_reset

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		do_reset(2'h3);
		chk8(hap_oe, 8'h00);
		chk8(hap_pu, 8'h00);
		chk8(dbp_pu, 8'h00);
		rc(A_HDIR, 32'h0000_00FF);
		rc(A_HDR, 32'h0000_003C);
		rc(A_BAD, 32'h0000_0000);
		wr(A_HDIR, 8'h0F);
		wr(A_HDR, 8'hA5);
		go(1'b0, 1'b0);
		chk8(hap_oe, 8'h0F);
		chk8(hap_out, 8'hA5);
		chk8(hap_pu, 8'hA0);
		rc(A_HDR, 32'h0000_0035);
		go(1'b0, 1'b1);
		chk8(hap_oe, 8'h0F);
		chk8(hap_out, 8'hA5);
		go(1'b0, 1'b0);
		wr(A_DDIR, 8'hF0);
		wr(A_DDR, 8'h96);
		go(1'b0, 1'b0);
		chk8(dbp_oe, 8'hF0);
		chk8(dbp_out, 8'h96);
		chk8(dbp_pu, 8'h06);
		rc(A_DDR, 32'h0000_009A);
		rc(A_DDIR, 32'h0000_00FF);
		go(1'b0, 1'b1);
		chk8(dbp_oe, 8'hF0);
		go(1'b0, 1'b0);
		wr(A_DDR, 8'h00);
		wr(A_CTRL, 8'h01);
		@(posedge clk_sys);
		shram_drive <= 1'b1;
		shram_rdata <= 8'h69;
		go(1'b0, 1'b0);
		chk8(dbp_oe, 8'hFF);
		chk8(dbp_out, 8'h69);
		chk8(dbp_pu, 8'h00);
		@(posedge clk_sys);
		shram_drive <= 1'b0;
		go(1'b0, 1'b0);
		chk8(dbp_oe, 8'h00);
		go(1'b0, 1'b1);
		chk8(dbp_oe, 8'h00);
		go(1'b1, 1'b0);
		chk8(hap_oe, 8'h00);
		chk8(hap_pu, 8'h00);
		chk8(dbp_oe, 8'h00);
		go(1'b0, 1'b0);
		chk8(dbp_oe, 8'h00);
		rc(A_DDR, 32'h0000_003A);
		rc(A_CTRL, 32'h0000_0004);
		$display("test mode3 done");
		do_reset(2'h1);
		@(posedge clk_sys);
		addr_hi <= 8'h1E;
		go(1'b0, 1'b0);
		chk8(hap_oe, 8'hFF);
		chk8(hap_out, 8'h1E);
		wr(A_HDIR, 8'h00);
		wr(A_HDR, 8'hFF);
		go(1'b0, 1'b0);
		chk8(hap_oe, 8'hFF);
		chk8(hap_pu, 8'h00);
		wr(A_DDIR, 8'hFF);
		wr(A_DDR, 8'h55);
		go(1'b0, 1'b0);
		chk8(dbp_oe, 8'h00);
		@(posedge clk_sys);
		ext_wr <= 1'b1;
		ext_wdata <= 8'hB4;
		go(1'b0, 1'b0);
		chk8(dbp_oe, 8'hFF);
		chk8(dbp_out, 8'hB4);
		go(1'b0, 1'b1);
		chk8(hap_out, 8'h00);
		chk8(dbp_oe, 8'h00);
		$display("test mode1 done");
		go(1'b0, 1'b0);
		do_reset(2'h2);
		chk8(dbp_oe, 8'hFF);
		wr(A_HDIR, 8'h0F);
		wr(A_HDR, 8'hF0);
		go(1'b0, 1'b0);
		chk8(hap_oe, 8'h0F);
		chk8(hap_out, 8'h1E);
		chk8(hap_pu, 8'hF0);
		rc(A_HDR, 32'h0000_0030);
		go(1'b0, 1'b1);
		chk8(hap_out, 8'h00);
		$display("test mode2 done");
		finish_test();
	end
endmodule : test_address_data_io_ports

`default_nettype wire
